// file: logic/dacc_pkg.sv
// Purpose: constants shared by the two-channel converter control block
// Assumes: 100 MHz core clock, byte-wide register port
// Notes:   register offsets are local choices
package dacc_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned CONV_TIME_NS       = 10000;
    localparam int unsigned CONV_CYCLES        = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W              = 14;
    localparam logic [CNT_W-1:0] CONV_LAST     = CNT_W'(CONV_CYCLES - 1);
    localparam int unsigned ADDR_W             = 2;
    localparam logic [ADDR_W-1:0] OFS_DATA2    = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_DATA3    = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 2'h3;
    localparam int unsigned BIT_OE3            = 7;
    localparam int unsigned BIT_OE2            = 6;
    localparam int unsigned BIT_JOINT          = 5;
    localparam logic [4:0]  CTRL_RSVD          = 5'h1f;
    localparam logic [7:0]  DATA_RESET         = 8'h00;
    localparam logic [7:0]  ZERO_BYTE          = 8'h00;
endpackage : dacc_pkg

// file: logic/dacc_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from outside the core clock domain
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
module dacc_sync (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dout <= 1'b0;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end
endmodule : dacc_sync

// file: logic/dacc_chan.sv
// Purpose: one converter channel: settle timer, held result, output drive
// Assumes: conv_en, out_en, restart from the same clock
// Notes:   level stands in for data/256 * reference
`timescale 1ns/1ps
module dacc_chan
    import dacc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       conv_en,
    input  wire logic       out_en,
    input  wire logic       hold,
    input  wire logic       restart,
    input  wire logic [7:0] data,
    output logic [7:0]      level_q,
    output logic            drive_q,
    output logic            busy_q
);
    logic [CNT_W-1:0] cnt_q;

    // settle timer; a data write restarts it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else if (hold) begin
            cnt_q  <= cnt_q;
        end else if (!conv_en) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else if (restart || (!busy_q && level_q != data)) begin
            cnt_q  <= '0;
            busy_q <= 1'b1;
        end else if (busy_q && cnt_q == CONV_LAST) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q  <= cnt_q + CNT_W'(1);
        end
    end

    // result holds until the next conversion completes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            level_q <= DATA_RESET;
        end else if (!hold && conv_en && busy_q && !restart && cnt_q == CONV_LAST) begin
            level_q <= data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            drive_q <= 1'b0;
        end else if (!hold) begin
            drive_q <= out_en;
        end
    end
endmodule : dacc_chan

// file: logic/dacc_top.sv
// Purpose: register and enable logic of a two-channel 8-bit converter
// Assumes: one clock, byte register port, module stop and standby pins
// Notes:   analog levels appear as 8-bit codes with a drive flag
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module dacc_top
    import dacc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    input  wire logic              module_stop,
    input  wire logic              standby,
    output logic [7:0]             channel2_analog_output,
    output logic                   channel2_output_drive,
    output logic [7:0]             channel3_analog_output,
    output logic                   channel3_output_drive
);
    // ****************************************************
    // synchronised power-down controls
    // ****************************************************
    logic run_s;
    logic stby_s;
    logic stop_q;

    // pin inverted so the synchroniser's reset state reads as stopped
    dacc_sync u_stop_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (!module_stop),
        .dout     (run_s)
    );

    dacc_sync u_stby_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (standby),
        .dout     (stby_s)
    );

    // stopped out of reset until the pin is seen low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stop_q <= 1'b1;
        end else begin
            stop_q <= !run_s;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    logic [7:0] channel2_conversion_data_q;
    logic [7:0] channel3_conversion_data_q;
    logic       channel3_output_enable_q;
    logic       channel2_output_enable_q;
    logic       joint_conversion_enable_q;
    logic       acc_ok;
    logic       wr2;
    logic       wr3;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        hit = (a == o);
    endfunction : hit

    assign acc_ok = !stop_q;
    assign wr2    = acc_ok && reg_wr && hit(reg_addr, OFS_DATA2);
    assign wr3    = acc_ok && reg_wr && hit(reg_addr, OFS_DATA3);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel2_conversion_data_q <= DATA_RESET;
        end else if (wr2) begin
            channel2_conversion_data_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel3_conversion_data_q <= DATA_RESET;
        end else if (wr3) begin
            channel3_conversion_data_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel3_output_enable_q  <= 1'b0;
            channel2_output_enable_q  <= 1'b0;
            joint_conversion_enable_q <= 1'b0;
        end else if (acc_ok && reg_wr && hit(reg_addr, OFS_CTRL)) begin
            channel3_output_enable_q  <= reg_wdata[BIT_OE3];
            channel2_output_enable_q  <= reg_wdata[BIT_OE2];
            joint_conversion_enable_q <= reg_wdata[BIT_JOINT];
        end
    end

    // ****************************************************
    // channels
    // ****************************************************
    logic       conv2;
    logic       conv3;
    logic       hold;
    logic [7:0] lvl2;
    logic [7:0] lvl3;
    logic       drv2;
    logic       drv3;
    logic       busy2;
    logic       busy3;

    assign conv2 = !stop_q && (channel2_output_enable_q || joint_conversion_enable_q);
    assign conv3 = !stop_q && (channel3_output_enable_q || joint_conversion_enable_q);
    assign hold  = stby_s;

    dacc_chan u_ch2 (
        .core_clk (core_clk),
        .rstn     (rstn),
        .conv_en  (conv2),
        .out_en   (!stop_q && channel2_output_enable_q),
        .hold     (hold),
        .restart  (wr2),
        .data     (channel2_conversion_data_q),
        .level_q  (lvl2),
        .drive_q  (drv2),
        .busy_q   (busy2)
    );

    dacc_chan u_ch3 (
        .core_clk (core_clk),
        .rstn     (rstn),
        .conv_en  (conv3),
        .out_en   (!stop_q && channel3_output_enable_q),
        .hold     (hold),
        .restart  (wr3),
        .data     (channel3_conversion_data_q),
        .level_q  (lvl3),
        .drive_q  (drv3),
        .busy_q   (busy3)
    );

    // ****************************************************
    // outputs
    // ****************************************************
    // code on the pin stands for code/256 of the reference; zero when not driven
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel2_analog_output <= ZERO_BYTE;
            channel2_output_drive  <= 1'b0;
        end else begin
            channel2_analog_output <= drv2 ? lvl2 : ZERO_BYTE;
            channel2_output_drive  <= drv2;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel3_analog_output <= ZERO_BYTE;
            channel3_output_drive  <= 1'b0;
        end else begin
            channel3_analog_output <= drv3 ? lvl3 : ZERO_BYTE;
            channel3_output_drive  <= drv3;
        end
    end

    // ****************************************************
    // read port
    // ****************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= ZERO_BYTE;
        end else if (reg_rd && acc_ok) begin
            case (reg_addr)
                OFS_DATA2: reg_rdata <= channel2_conversion_data_q;
                OFS_DATA3: reg_rdata <= channel3_conversion_data_q;
                OFS_CTRL:  reg_rdata <= {channel3_output_enable_q, channel2_output_enable_q,
                                         joint_conversion_enable_q, CTRL_RSVD};
                OFS_STATUS: reg_rdata <= {6'h00, busy3, busy2};
                default:   reg_rdata <= ZERO_BYTE;
            endcase
        end else begin
            reg_rdata <= ZERO_BYTE;
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    ctrl_rsvd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_rd && acc_ok && reg_addr == OFS_CTRL) |=> (reg_rdata[4:0] == CTRL_RSVD))
        else $error("reserved control bits not read as one");

    drive_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!stop_q && !stby_s && $stable(channel2_output_enable_q)) |=> ##1
        (channel2_output_drive == $past(channel2_output_enable_q, 2)))
        else $error("channel 2 drive does not follow its enable");

    joint_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (joint_conversion_enable_q && !channel2_output_enable_q && !channel3_output_enable_q
         && !stop_q && !stby_s)[*2] |-> (conv2 && conv3) ##1
        (!channel2_output_drive && !channel3_output_drive))
        else $error("joint enable does not keep both converting undriven");

    stop_reset_a: assert property (@(posedge core_clk) disable iff (!rstn)
        stop_q |=> $stable(channel2_conversion_data_q) && $stable(channel3_output_enable_q))
        else $error("register changed while module stopped");

    restart_busy_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr2 && conv2 && !stby_s) |=> busy2)
        else $error("data write did not restart conversion");

    disable_stop_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!channel3_output_enable_q && !stby_s)[*2] |=> !channel3_output_drive)
        else $error("channel 3 still driven after disable");

    result_time_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (busy2 && !stby_s && conv2 && !wr2 && u_ch2.cnt_q == CONV_LAST) |=>
        (lvl2 == channel2_conversion_data_q))
        else $error("result not taken at end of conversion time");

    hold_stby_a: assert property (@(posedge core_clk) disable iff (!rstn)
        stby_s |=> $stable(lvl3) && $stable(drv3))
        else $error("output not held in standby");

    // ****************************************************
    // register, read port and channel checks
    // ****************************************************
    data2_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr2 |=> (channel2_conversion_data_q == $past(reg_wdata)))
        else $error("channel 2 data write lost");

    data3_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr3 |=> (channel3_conversion_data_q == $past(reg_wdata)))
        else $error("channel 3 data write lost");

    data2_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_rd && acc_ok && reg_addr == OFS_DATA2) |=>
        (reg_rdata == $past(channel2_conversion_data_q)))
        else $error("channel 2 data read back wrong");

    data3_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_rd && acc_ok && reg_addr == OFS_DATA3) |=>
        (reg_rdata == $past(channel3_conversion_data_q)))
        else $error("channel 3 data read back wrong");

    status_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_rd && acc_ok && reg_addr == OFS_STATUS) |=>
        (reg_rdata == {6'h00, $past(busy3), $past(busy2)}))
        else $error("status read back wrong");

    idle_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !reg_rd |=> (reg_rdata == ZERO_BYTE))
        else $error("read data not zero without a read");

    stop_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_rd && stop_q) |=> (reg_rdata == ZERO_BYTE))
        else $error("read answered while module stopped");

    oe3_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (acc_ok && reg_wr && reg_addr == OFS_CTRL) |=>
        (channel3_output_enable_q == $past(reg_wdata[BIT_OE3])))
        else $error("channel 3 enable not written");

    oe2_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (acc_ok && reg_wr && reg_addr == OFS_CTRL) |=>
        (channel2_output_enable_q == $past(reg_wdata[BIT_OE2])))
        else $error("channel 2 enable not written");

    joint_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (acc_ok && reg_wr && reg_addr == OFS_CTRL) |=>
        (joint_conversion_enable_q == $past(reg_wdata[BIT_JOINT])))
        else $error("joint enable not written");

    chan2_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!joint_conversion_enable_q && !channel2_output_enable_q && !stby_s) |=> !busy2)
        else $error("channel 2 converts while disabled");

    chan3_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!joint_conversion_enable_q && !channel3_output_enable_q && !stby_s) |=> !busy3)
        else $error("channel 3 converts while disabled");

    chan2_settle_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (conv2 && !stby_s && !busy2) |=>
        (busy2 || (lvl2 == $past(channel2_conversion_data_q))))
        else $error("channel 2 result does not track its data");

    chan3_settle_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (conv3 && !stby_s && !busy3) |=>
        (busy3 || (lvl3 == $past(channel3_conversion_data_q))))
        else $error("channel 3 result does not track its data");

    out2_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
        drv2 |=> (channel2_analog_output == $past(lvl2)))
        else $error("channel 2 output code differs from result");

    out3_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
        drv3 |=> (channel3_analog_output == $past(lvl3)))
        else $error("channel 3 output code differs from result");

    out2_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !drv2 |=> (channel2_analog_output == ZERO_BYTE))
        else $error("channel 2 output code shown while undriven");

    out3_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !drv3 |=> (channel3_analog_output == ZERO_BYTE))
        else $error("channel 3 output code shown while undriven");

    drive3_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!stop_q && !stby_s && $stable(channel3_output_enable_q)) |=> ##1
        (channel3_output_drive == $past(channel3_output_enable_q, 2)))
        else $error("channel 3 drive does not follow its enable");

    disable2_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!channel2_output_enable_q && !stby_s)[*2] |=> !channel2_output_drive)
        else $error("channel 2 still driven after disable");

    stop_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (stop_q && !stby_s) |=> (!drv2 && !drv3))
        else $error("output driven while module stopped");

    busy2_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
        busy2 |-> (u_ch2.cnt_q <= CONV_LAST))
        else $error("channel 2 settle count overran");

    busy3_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
        busy3 |-> (u_ch3.cnt_q <= CONV_LAST))
        else $error("channel 3 settle count overran");

    restart3_busy_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr3 && conv3 && !stby_s) |=> busy3)
        else $error("channel 3 data write did not restart conversion");

    result3_time_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (busy3 && !stby_s && conv3 && !wr3 && u_ch3.cnt_q == CONV_LAST) |=>
        (lvl3 == channel3_conversion_data_q))
        else $error("channel 3 result not taken at end of conversion time");

    hold2_stby_a: assert property (@(posedge core_clk) disable iff (!rstn)
        stby_s |=> ($stable(lvl2) && $stable(drv2)))
        else $error("channel 2 output not held in standby");
endmodule : dacc_top

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the two-channel converter control
// Assumes: bench drives module stop and standby pins directly
// Notes:   random data from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module tb_top
    import dacc_pkg::*;
;
    logic              core_clk;
    logic              rstn;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_rdata;
    logic              module_stop;
    logic              standby;
    logic [7:0]        lvl2;
    logic              drv2;
    logic [7:0]        lvl3;
    logic              drv3;
    logic [7:0]        v;
    logic [7:0]        d2;
    logic [7:0]        d3;
    int                seed;
    int                n_errors;
    int                samples_checked;
    int                cycles;

    dacc_top i_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .module_stop(module_stop), .standby(standby), .channel2_analog_output(lvl2),
        .channel2_output_drive(drv2), .channel3_analog_output(lvl3),
        .channel3_output_drive(drv3));

    always #5 core_clk = ~core_clk;

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic conclude();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            conclude();
        end
    end

    // ****************************************
    // register port tasks
    // ****************************************
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // waits for a driven output carrying the expected code
    task automatic wait_lvl(input logic ch3, input logic [7:0] e);
        int i;
        for (i = 0; i < 1100; i++) begin
            @(posedge core_clk);
            #1;
            if ((ch3 ? drv3 : drv2) === 1'b1 && (ch3 ? lvl3 : lvl2) === e) break;
        end
        chk("level", e, ch3 ? lvl3 : lvl2);
        chk("drive", 8'h01, {7'h00, ch3 ? drv3 : drv2});
    endtask : wait_lvl

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 70700;
        core_clk = 1'b0;
        rstn = 1'b0;
        reg_addr = '0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        module_stop = 1'b1;
        standby = 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        wr(OFS_DATA2, 8'h5a);
        module_stop <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(OFS_DATA2, v); chk("data2 reset", DATA_RESET, v);
        rd(OFS_DATA3, v); chk("data3 reset", DATA_RESET, v);
        rd(OFS_CTRL, v); chk("ctrl reset", 8'h1f, v);
        for (int k = 0; k < 8; k++) begin
            d2 = 8'($random(seed));
            wr(OFS_CTRL, {k[2:0], d2[4:0]});
            rd(OFS_CTRL, v); chk("ctrl", {k[2:0], 5'h1f}, v);
            repeat (3) @(posedge core_clk);
            #1;
            chk("drive2", {7'h00, k[1]}, {7'h00, drv2});
            chk("drive3", {7'h00, k[2]}, {7'h00, drv3});
        end
        wr(OFS_CTRL, 8'h00);
        for (int k = 0; k < 6; k++) begin
            d2 = 8'($random(seed));
            wr(k[0] ? OFS_DATA3 : OFS_DATA2, d2);
            rd(k[0] ? OFS_DATA3 : OFS_DATA2, v); chk("data", d2, v);
        end
        d2 = 8'($random(seed));
        d3 = 8'($random(seed));
        d2[7] = 1'b1;
        d3[0] = 1'b1;
        wr(OFS_DATA2, d2);
        wr(OFS_DATA3, d3);
        wr(OFS_CTRL, 8'h40);
        wait_lvl(1'b0, d2);
        chk("drive3 off", 8'h00, {7'h00, drv3});
        wr(OFS_CTRL, 8'hc0);
        wait_lvl(1'b1, d3);
        wr(OFS_DATA2, ~d2);
        repeat (500) @(posedge core_clk);
        #1;
        chk("held level", d2, lvl2);
        wait_lvl(1'b0, ~d2);
        @(posedge core_clk);
        standby <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        chk("standby level", ~d2, lvl2);
        chk("standby drive", 8'h01, {7'h00, drv2});
        @(posedge core_clk);
        standby <= 1'b0;
        wr(OFS_CTRL, 8'h20);
        repeat (4) @(posedge core_clk);
        #1;
        chk("off drive", 8'h00, {6'h00, drv3, drv2});
        chk("off level", 8'h00, lvl2 | lvl3);
        wr(OFS_DATA3, d2);
        rd(OFS_STATUS, v); chk("status", 8'h02, v);
        wr(OFS_STATUS, 8'hff);
        rd(OFS_CTRL, v); chk("ctrl kept", 8'h3f, v);
        conclude();
    end
endmodule : tb_top
